// *** common/hft_pkg.sv ***
// Package for the hub (micro)frame timer: timing constants and a carrier struct.
// Assumes a single 50 MHz clock domain; bit-time rate arrives as an enable pulse.
package hft_pkg;

    localparam int CNT_W = 16;

    // Interval window and nominal period, bit times
    localparam logic [15:0] HS_MIN_INTERVAL  = 16'hEA00;  // 59904
    localparam logic [15:0] HS_MAX_INTERVAL  = 16'hEAC0;  // 60096
    localparam logic [15:0] HS_NOM_INTERVAL  = 16'hEA60;  // 60000
    localparam logic [15:0] FS_MIN_INTERVAL  = 16'h2EB6;  // 11958
    localparam logic [15:0] FS_MAX_INTERVAL  = 16'h2F0A;  // 12042
    localparam logic [15:0] FS_NOM_INTERVAL  = 16'h2EE0;  // 12000

    // Rollover test points
    localparam logic [15:0] HS_ROLLOVER      = 16'hFFFF;  // 65535
    localparam logic [15:0] FS_ROLLOVER      = 16'h3FFF;  // 16383

    // EOF points before end of (micro)frame
    localparam logic [15:0] HS_EOF1_BITS     = 16'h0230;  // 560
    localparam logic [15:0] HS_EOF2_BITS     = 16'h0040;  // 64
    localparam logic [15:0] FS_EOF1_BITS     = 16'h0020;  // 32
    localparam logic [15:0] FS_EOF2_BITS     = 16'h000A;  // 10

    // SOF processing delay range used for advancement
    localparam logic [15:0] HS_ADV_MIN       = 16'h0028;  // 40
    localparam logic [15:0] HS_ADV_MAX       = 16'h00C0;  // 192
    localparam logic [15:0] FS_ADV_MIN       = 16'h0010;  // 16
    localparam logic [15:0] FS_ADV_MAX       = 16'h0014;  // 20

    // Default advancement applied by this implementation
    localparam logic [15:0] HS_ADV_DEFAULT   = 16'h0040;  // 64
    localparam logic [15:0] FS_ADV_DEFAULT   = 16'h0010;  // 16

    typedef struct packed {
        logic locked;
        logic eof1;
        logic eof2;
        logic eof;
    } hft_marks_t;

endpackage

// *** verif/hft_sof_source.sv ***
// SOF source model: the upstream party that sends SOF tokens.
// Assumes ref_clk from the bench; one hub bit time per clock.
`timescale 1ns/100ps
module hft_sof_source
(
    input  wire logic ref_clk,
    output logic      bitTick,
    output logic      sofSeen
);
    initial
    begin
        bitTick = 1'b0;
        sofSeen = 1'b0;
    end

    // One SOF pulse, then n bit times
    task automatic sendSof(input int n);
        @(posedge ref_clk);
        sofSeen <= 1'b1;
        bitTick <= 1'b0;
        @(posedge ref_clk);
        sofSeen <= 1'b0;
        bitTick <= 1'b1;
        repeat (n) @(posedge ref_clk);
    endtask
endmodule

// *** verif/hub_frame_timer_sync_tb.sv ***
// Bench for the frame timer: lock, free run, EOF marks, misses, clears.
// Assumes the SOF source model; bit time equals one clock.
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin comparisons++; if ((got) !== (ex)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module hub_frame_timer_sync_tb;
    logic                ref_clk   = 1'b0;
    logic                nrst      = 1'b0;
    logic                highSpeed = 1'b0;
    logic                hubReset  = 1'b0;
    logic                resumeEvt = 1'b0;
    logic [3:0]          upConnReq = 4'h0;
    logic                bitTick;
    logic                sofSeen;
    wire hft_pkg::hft_marks_t marks;
    logic [3:0]          upConnGrant;
    logic [3:0]          babbleDisable;
    int                  err_count   = 0;
    int                  comparisons = 0;
    int                  k;

    always #10 ref_clk = ~ref_clk;

    hft_sof_source src (.ref_clk(ref_clk), .bitTick(bitTick), .sofSeen(sofSeen));

    hft_frame_timer dut (.ref_clk(ref_clk), .nrst(nrst), .highSpeed(highSpeed), .bitTick(bitTick),
        .sofSeen(sofSeen), .hubReset(hubReset), .resumeEvt(resumeEvt), .upConnReq(upConnReq),
        .timerLocked(marks.locked), .eof1Mark(marks.eof1), .eof2Mark(marks.eof2),
        .eofMark(marks.eof), .upConnGrant(upConnGrant), .babbleDisable(babbleDisable));

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Cycles until mark bit b is high
    task automatic gap(input int b, input int lim);
        k = 0;
        while (marks[b] !== 1'b1 && k < lim)
        begin
            step(1);
            k++;
        end
    endtask

    task automatic lock_up();
        src.sendSof(12000);
        `CHK("grant before lock", 4'h0, upConnGrant)
        src.sendSof(1);
        step(3);
        `CHK("locked", 1'b1, marks.locked)
        `CHK("grant", upConnReq, upConnGrant)
        $display("Test lock finished");
    endtask

    task automatic free_run();
        gap(2, 12100);
        `CHK("eof1 seen", 1'b1, marks.eof1)
        gap(1, 100);
        `CHK("eof1 to eof2", 22, k)
        gap(0, 100);
        `CHK("eof2 to eof", 26, k)
        step(2);
        `CHK("babble", 4'h1, babbleDisable)
        `CHK("still locked", 1'b1, marks.locked)
        $display("Test free run finished");
    endtask

    task automatic miss(input int n, input string s);
        src.sendSof(n);
        src.sendSof(1);
        step(3);
        `CHK(s, 1'b0, marks.locked)
        $display("Test %s finished", s);
    endtask

    task automatic clear_by(input logic useResume);
        @(posedge ref_clk);
        hubReset <= ~useResume;
        resumeEvt <= useResume;
        step(3);
        hubReset <= 1'b0;
        resumeEvt <= 1'b0;
        step(6);
        `CHK("unlocked", 1'b0, marks.locked)
        `CHK("grant cleared", 4'h0, upConnGrant)
        $display("Test clear finished");
    endtask

    task automatic end_of_test();
        $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        step(19);
        `CHK("locked in reset", 1'b0, marks.locked)
        `CHK("babble in reset", 4'h0, babbleDisable)
        @(posedge ref_clk);
        nrst <= 1'b1;
        upConnReq <= 4'h1;
        lock_up();
        free_run();
        clear_by(1'b0);
        `CHK("babble sticky", 4'h1, babbleDisable)
        miss(11000, "short interval");
        miss(17000, "rollover");
        lock_up();
        clear_by(1'b1);
        @(posedge ref_clk);
        nrst <= 1'b0;
        highSpeed <= 1'b1;
        step(3);
        @(posedge ref_clk);
        nrst <= 1'b1;
        miss(12000, "high speed");
        end_of_test();
    end

    initial
    begin
        repeat (95000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end
endmodule

// *** verilog/hft_frame_timer.sv ***
// Hub (micro)frame timer: locks to SOF spacing and marks EOF1, EOF2 and EOF.
// Assumes sofSeen and bitTick come from logic on ref_clk, one-cycle pulses;
// hubReset and resumeEvt are asynchronous levels/pulses from outside.
`timescale 1ns/100ps

// Notes on behaviour
// RULE_01 - High speed accepts 59904 to 60096 bits
// RULE_02 - Full speed accepts 11958 to 12042 bits
// RULE_03 - Reset or resume drops lock
// RULE_04 - Two consecutive SOFs bring lock
// RULE_05 - Down timer, up interval, holding register, flag
// RULE_06 - First SOF clears interval, counts bit times
// RULE_07 - Good SOF loads hold and timer, locks
// RULE_08 - Rollover at 65535 or 16383
// RULE_09 - SOF after rollover is a miss
// RULE_10 - Timer zero reloads from holding register
// RULE_11 - SOF after rollover loads timer from hold
// RULE_12 - EOF is where timer reaches zero
// RULE_13 - EOF points advanced by SOF decode time
// RULE_14 - Advance 40-192 HS, 16-20 FS
// RULE_15 - Lock output only when EOF points valid
// RULE_16 - Block downstream connectivity until lock after resume
// RULE_17 - HS EOF2 at 64, EOF1 at 560
// RULE_18 - EOF2 disables ports holding upstream connectivity
// RULE_19 - 16-bit counters cleared with lock on reset
module hft_frame_timer
#(
    parameter int          NPORTS  = 4,
    parameter logic [15:0] HS_ADV  = hft_pkg::HS_ADV_DEFAULT,
    parameter logic [15:0] FS_ADV  = hft_pkg::FS_ADV_DEFAULT
)
(
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              highSpeed,
    input  wire logic              bitTick,
    input  wire logic              sofSeen,
    input  wire logic              hubReset,
    input  wire logic              resumeEvt,
    input  wire logic [NPORTS-1:0] upConnReq,
    output logic                   timerLocked,
    output logic                   eof1Mark,
    output logic                   eof2Mark,
    output logic                   eofMark,
    output logic [NPORTS-1:0]      upConnGrant,
    output logic [NPORTS-1:0]      babbleDisable
);

    // Synchronisers for the asynchronous controls
    logic [1:0] rstSync_reg;
    logic [1:0] resSync_reg;
    logic       resPrev_reg;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstSync_reg <= 2'h0;
            resSync_reg <= 2'h0;
            resPrev_reg <= 1'b0;
        end
        else
        begin
            rstSync_reg <= {rstSync_reg[0], hubReset};
            resSync_reg <= {resSync_reg[0], resumeEvt};
            resPrev_reg <= resSync_reg[1];
        end
    end

    wire clearSync = rstSync_reg[1] | (resSync_reg[1] & ~resPrev_reg); // RULE_03

    // Counters and state
    logic [15:0] downCnt_reg; // RULE_05
    logic [15:0] upCnt_reg;
    logic [15:0] holdCnt_reg;
    logic        unsync_reg;
    logic        started_reg;
    logic        rolled_reg;
    logic        heldValid_reg;

    wire [15:0] rollPoint = highSpeed ? hft_pkg::HS_ROLLOVER : hft_pkg::FS_ROLLOVER;
    wire [15:0] minIntv   = highSpeed ? hft_pkg::HS_MIN_INTERVAL : hft_pkg::FS_MIN_INTERVAL;
    wire [15:0] maxIntv   = highSpeed ? hft_pkg::HS_MAX_INTERVAL : hft_pkg::FS_MAX_INTERVAL;
    wire        inWindow  = (upCnt_reg >= minIntv) && (upCnt_reg <= maxIntv); // RULE_01 RULE_02
    wire        rollNow   = bitTick && (upCnt_reg == rollPoint);               // RULE_08
    wire        goodSof   = sofSeen && started_reg && !rolled_reg && inWindow; // RULE_07
    wire        missSof   = sofSeen && started_reg && !goodSof;                // RULE_09
    wire        atZero    = bitTick && (downCnt_reg == 16'h0000);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            downCnt_reg   <= 16'h0000; // RULE_19
            upCnt_reg     <= 16'h0000;
            holdCnt_reg   <= 16'h0000;
            unsync_reg    <= 1'b1;
            started_reg   <= 1'b0;
            rolled_reg    <= 1'b0;
            heldValid_reg <= 1'b0;
        end
        else if (clearSync)
        begin
            downCnt_reg   <= 16'h0000; // RULE_19
            upCnt_reg     <= 16'h0000;
            holdCnt_reg   <= 16'h0000;
            unsync_reg    <= 1'b1;     // RULE_03
            started_reg   <= 1'b0;
            rolled_reg    <= 1'b0;
            heldValid_reg <= 1'b0;
        end
        else if (sofSeen)
        begin
            started_reg <= 1'b1;
            upCnt_reg   <= 16'h0000;   // RULE_06
            rolled_reg  <= 1'b0;
            if (goodSof)
            begin
                holdCnt_reg   <= upCnt_reg; // RULE_07
                downCnt_reg   <= upCnt_reg;
                unsync_reg    <= 1'b0;      // RULE_04
                heldValid_reg <= 1'b1;
            end
            else if (missSof)
            begin
                downCnt_reg <= holdCnt_reg; // RULE_11
                unsync_reg  <= 1'b1;        // RULE_09
            end
        end
        else if (bitTick)
        begin
            if (started_reg && !rolled_reg)
                upCnt_reg <= upCnt_reg + 16'h0001; // RULE_06
            if (rollNow)
                rolled_reg <= 1'b1;               // RULE_08
            if (heldValid_reg)
                downCnt_reg <= (downCnt_reg == 16'h0000) ? holdCnt_reg : downCnt_reg - 16'h0001; // RULE_10
        end
    end

    // EOF points, advanced by the SOF processing delay
    wire [15:0] advance = highSpeed ? HS_ADV : FS_ADV;                            // RULE_14
    wire [15:0] eof1Off = highSpeed ? hft_pkg::HS_EOF1_BITS : hft_pkg::FS_EOF1_BITS; // RULE_17
    wire [15:0] eof2Off = highSpeed ? hft_pkg::HS_EOF2_BITS : hft_pkg::FS_EOF2_BITS; // RULE_17
    wire [15:0] eof1Pt  = eof1Off + advance;                                      // RULE_13
    wire [15:0] eof2Pt  = eof2Off + advance;                                      // RULE_13
    wire        validPt = ~unsync_reg & heldValid_reg;                            // RULE_15

    hft_pkg::hft_marks_t marks_next;
    assign marks_next.locked = validPt;
    assign marks_next.eof1   = validPt && bitTick && (downCnt_reg == eof1Pt);
    assign marks_next.eof2   = validPt && bitTick && (downCnt_reg == eof2Pt);
    assign marks_next.eof    = validPt && atZero;                                 // RULE_12

    // Connectivity tracking per port
    logic [NPORTS-1:0] conn_reg;
    wire  [NPORTS-1:0] grantNext = upConnReq & {NPORTS{validPt}};                 // RULE_16

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            timerLocked   <= 1'b0;
            eof1Mark      <= 1'b0;
            eof2Mark      <= 1'b0;
            eofMark       <= 1'b0;
            conn_reg      <= '0;
            upConnGrant   <= '0;
            babbleDisable <= '0;
        end
        else
        begin
            timerLocked   <= marks_next.locked; // RULE_15
            eof1Mark      <= marks_next.eof1;
            eof2Mark      <= marks_next.eof2;
            eofMark       <= marks_next.eof;
            conn_reg      <= grantNext;
            upConnGrant   <= grantNext;         // RULE_16
            babbleDisable <= marks_next.eof2 ? (babbleDisable | conn_reg) : babbleDisable; // RULE_18
        end
    end

    // Checks
    chk_lock_after_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        clearSync |=> ##1 !timerLocked) else $error("lock held after reset or resume"); // RULE_03
    chk_good_sof_locks: assert property (@(posedge ref_clk) disable iff (!nrst)
        (goodSof && !clearSync) |=> ##1 timerLocked) else $error("good SOF did not lock"); // RULE_04
    chk_hold_loaded: assert property (@(posedge ref_clk) disable iff (!nrst)
        (goodSof && !clearSync) |=> holdCnt_reg == $past(upCnt_reg)) else $error("hold not loaded"); // RULE_07
    chk_miss_no_lock: assert property (@(posedge ref_clk) disable iff (!nrst)
        (missSof && !clearSync) |=> unsync_reg) else $error("missed SOF set lock"); // RULE_09
    chk_miss_reload: assert property (@(posedge ref_clk) disable iff (!nrst)
        (missSof && !clearSync) |=> downCnt_reg == $past(holdCnt_reg)) else $error("miss reload wrong"); // RULE_11
    chk_zero_reload: assert property (@(posedge ref_clk) disable iff (!nrst)
        (atZero && heldValid_reg && !sofSeen && !clearSync) |=> downCnt_reg == $past(holdCnt_reg))
        else $error("zero reload wrong"); // RULE_10
    chk_grant_locked: assert property (@(posedge ref_clk) disable iff (!nrst)
        (upConnGrant != '0) |-> $past(validPt)) else $error("grant while unlocked"); // RULE_16
    chk_up_rollover: assert property (@(posedge ref_clk) disable iff (!nrst)
        rollNow && !sofSeen && !clearSync |=> rolled_reg) else $error("rollover not flagged"); // RULE_08
    chk_eof_locked: assert property (@(posedge ref_clk) disable iff (!nrst)
        eofMark |-> $past(validPt)) else $error("EOF while unlocked"); // RULE_12
    chk_window_miss: assert property (@(posedge ref_clk) disable iff (!nrst)
        (sofSeen && started_reg && !inWindow && !clearSync) |=> unsync_reg)
        else $error("out of window SOF locked"); // RULE_01 RULE_02
    chk_babble_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> ((babbleDisable & $past(babbleDisable)) == $past(babbleDisable)))
        else $error("babble disable dropped"); // RULE_18

    cov_lock:   cover property (@(posedge ref_clk) disable iff (!nrst) $rose(timerLocked));
    cov_eof2:   cover property (@(posedge ref_clk) disable iff (!nrst) eof2Mark);
    cov_miss:   cover property (@(posedge ref_clk) disable iff (!nrst) missSof && heldValid_reg);
    cov_babble: cover property (@(posedge ref_clk) disable iff (!nrst) babbleDisable != '0);

endmodule
